/* File: src/pprsc_ctrl.sv */
// power-up clear, preload, signature, security and sleep control of a registered logic device
// What the document requires of this block, the board and the programmer
// RULE1: power-up clears every macrocell register low; pin level follows output polarity.
// RULE2: board meets input and feedback setup before first rising clock after clear.
// RULE3: board keeps clock steady during the power-up clear interval, at most 1000 ns.
// RULE4: preload forces each register individually to one or zero.
// RULE5: a 64-bit user signature stays readable always, even when secured.
// RULE6: one security fuse blocks verify readback and preload at once, not signature reads.
// RULE7: programmer should program the security fuse as the last step.
// RULE8: undriven input and bidirectional pins keep their last level. The shared sleep pin is not kept: its keeper always sees it as driven.
// RULE9: sleep enabled and sleep pin high freezes outputs and internal state.
// RULE10: while asleep every input and clock is ignored except the sleep pin.
// RULE11: outputs disabled or undetermined at sleep entry stay that way.
// RULE12: with sleep disabled the shared sleep pin is an ordinary array input.
// RULE13: with sleep enabled the sleep pin's array input term is unused.
// RULE14: one extra fuse enables sleep; images hold 5828, 5892 or 5893 bits.
// RULE15: sleep pin is level sensitive; wake resumes from the frozen state.
// RULE16: power-up clear is asynchronous and finishes before a clock edge is taken.
`default_nettype none
module pprsc_ctrl #(
    parameter int            NI       = 12,    // dedicated input pins
    parameter int            NM       = 10,    // macrocells and their pins
    parameter logic [NM-1:0] POLARITY = '0     // output buffer inversion per pin
) (
    input  wire logic                           clk_sys,          // system clock
    input  wire logic                           reset_n,          // power-up reset, active low
    input  wire logic [NI-1:0]                  in_pin,           // dedicated input pins
    input  wire logic [NI-1:0]                  in_driven,        // outside driver active on inputs
    input  wire logic [NM-1:0]                  io_in,            // bidirectional pin levels
    input  wire logic [NM-1:0]                  io_driven,        // outside driver active on i/o
    input  wire logic                           shared_input_sleep_pin, // sleep or plain input pin
    input  wire logic                           cfg_sleep_enable, // sleep fuse programmed
    input  wire logic                           cfg_sig_present,  // image carries the signature
    input  wire logic                           cfg_secure,       // security fuse programmed
    input  wire logic [NM-1:0]                  array_next,       // macrocell next state from array
    input  wire logic [NM-1:0]                  array_oe,         // output enables from array
    input  wire logic                           preload_req,      // preload strobe
    input  wire logic [NM-1:0]                  preload_mask,     // registers to force
    input  wire logic [NM-1:0]                  preload_value,    // forced levels
    input  wire logic                           verify_req,       // readback strobe
    input  wire logic [pprsc_pkg::VERIFY_W-1:0] cfg_word,         // configuration word to read back
    input  wire logic                           sig_wr_req,       // signature program strobe
    input  wire logic [pprsc_pkg::SIG_BITS-1:0] sig_wr_data,      // signature program data
    input  wire logic                           sig_rd_req,       // signature read strobe
    output logic      [NM-1:0]                  io_out,           // pin output levels
    output logic      [NM-1:0]                  io_oe,            // pin drive enables, high drives
    output logic      [NM-1:0]                  feedback,         // macrocell register feedback
    output logic      [NI:0]                    array_in,         // array inputs, sleep term on top
    output logic      [NM-1:0]                  io_level,         // kept i/o levels into the array
    output logic                                ready,            // power-up clear complete
    output logic                                asleep,           // frozen
    output logic                                preload_denied,   // last preload refused
    output logic                                verify_valid,     // readback answer
    output logic      [pprsc_pkg::VERIFY_W-1:0] verify_data,      // readback data, zero if secured
    output logic                                verify_denied,    // readback refused
    output logic                                sig_valid,        // signature answer
    output logic      [pprsc_pkg::SIG_BITS-1:0] sig_data,         // signature contents
    output logic      [pprsc_pkg::FUSE_CNT_W-1:0] fuse_count      // image size of current mode
);
    logic [NI-1:0]                    in_lvl;
    logic [NM-1:0]                    io_lvl;
    logic                             sleep_lvl;
    logic                             asleep_now;
    logic                             take_edge;
    logic [NM-1:0]                    macro_reg;
    logic [NM-1:0]                    macro_next;
    logic [pprsc_pkg::CLR_CNT_W-1:0]  clr_cnt_reg;
    logic [pprsc_pkg::SIG_BITS-1:0]   sig_store_reg;

    // image size follows the mode fuses
    function automatic logic [pprsc_pkg::FUSE_CNT_W-1:0] image_size(input logic sleep_fuse, input logic sig);
        if (sleep_fuse) begin
            image_size = pprsc_pkg::FUSES_SLEEP;   // [RULE14]
        end else if (sig) begin
            image_size = pprsc_pkg::FUSES_SIG;     // [RULE14]
        end else begin
            image_size = pprsc_pkg::FUSES_BASIC;   // [RULE14]
        end
    endfunction

    // all pins pass the synchroniser; the sleep pin keeper never holds, its driver flag is tied high; i/o keepers see our own drive
    pprsc_pin_keep #(.W(NI)) u_keep_in (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .pin_in     (in_pin),
        .pin_driven (in_driven),
        .own_oe     ({NI{1'b0}}),
        .own_out    ({NI{1'b0}}),
        .level      (in_lvl)
    );
    pprsc_pin_keep #(.W(NM)) u_keep_io (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .pin_in     (io_in),
        .pin_driven (io_driven),
        .own_oe     (io_oe),
        .own_out    (io_out),
        .level      (io_lvl)
    );
    pprsc_pin_keep #(.W(1)) u_keep_sleep (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .pin_in     (shared_input_sleep_pin),
        .pin_driven (1'b1),
        .own_oe     (1'b0),
        .own_out    (1'b0),
        .level      (sleep_lvl)
    );

    // level sensitive: sleep lasts exactly as long as the pin stays high
    assign asleep_now = cfg_sleep_enable & sleep_lvl;   // [RULE9] [RULE15]
    // edges count only after the clear settles and while awake
    assign take_edge  = ready & ~asleep_now;            // [RULE10] [RULE16]

    // preload wins over the array in the same cycle; security blocks it
    always_comb begin
        if (preload_req && !cfg_secure) begin
            macro_next = (macro_reg & ~preload_mask) | (preload_value & preload_mask); // [RULE4] [RULE6]
        end else begin
            macro_next = array_next;
        end
    end

    // clear settle counter; edges before it runs out are not taken
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clr_cnt_reg <= pprsc_pkg::CLR_CNT_RST;
            ready       <= 1'b0;
        end else if (!ready) begin
            clr_cnt_reg <= clr_cnt_reg + 7'h01;
            ready       <= (clr_cnt_reg == pprsc_pkg::CLEAR_CYC - 7'h01);   // [RULE16]
        end
    end

    // macrocell registers: async clear to low, frozen while asleep
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            macro_reg <= '0;                   // [RULE1] [RULE16]
            io_out    <= POLARITY;             // [RULE1]
            io_oe     <= '0;
        end else if (take_edge) begin
            macro_reg <= macro_next;
            io_out    <= macro_next ^ POLARITY; // [RULE1]
            io_oe     <= array_oe;              // [RULE11]
        end
    end
    assign feedback = macro_reg;

    // array input latches; the sleep pin term drops out once sleep is enabled
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            array_in <= '0;
            io_level <= '0;
        end else if (!asleep_now) begin
            array_in <= {sleep_lvl & ~cfg_sleep_enable, in_lvl};   // [RULE10] [RULE12] [RULE13]
            io_level <= io_lvl;                                    // [RULE10]
        end else begin
            array_in[NI] <= 1'b0;   // term unused whenever sleep is enabled
        end
    end

    // status flags
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            asleep         <= 1'b0;
            preload_denied <= 1'b0;
            fuse_count     <= pprsc_pkg::FUSES_BASIC;
        end else begin
            asleep     <= asleep_now;
            fuse_count <= image_size(cfg_sleep_enable, cfg_sig_present);
            if (preload_req && take_edge) begin
                preload_denied <= cfg_secure;   // [RULE6]
            end
        end
    end

    // configuration readback; the fuse acts at once, no latching of it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            verify_valid  <= 1'b0;
            verify_denied <= 1'b0;
            verify_data   <= pprsc_pkg::VERIFY_RST;
        end else begin
            verify_valid  <= verify_req;
            if (verify_req) begin
                verify_denied <= cfg_secure;                                  // [RULE6]
                verify_data   <= cfg_secure ? pprsc_pkg::VERIFY_RST : cfg_word; // [RULE6]
            end
        end
    end

    // signature store; reads ignore the security fuse
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sig_store_reg <= pprsc_pkg::SIG_RST;
            sig_valid     <= 1'b0;
            sig_data      <= pprsc_pkg::SIG_RST;
        end else begin
            if (sig_wr_req) begin
                sig_store_reg <= sig_wr_data;
            end
            sig_valid <= sig_rd_req;                 // [RULE5]
            if (sig_rd_req) begin
                sig_data <= sig_store_reg;           // [RULE5]
            end
        end
    end

    a_clear_low: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE1] [RULE16]
        !ready |-> (macro_reg == '0 && io_out == POLARITY && io_oe == '0))
        else $error("registers not cleared before clock edges are taken");
    a_clear_span: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE16]
        (!ready && clr_cnt_reg == pprsc_pkg::CLEAR_CYC - 7'h01) |=> ready ##1 ready)
        else $error("clear interval end not reached on time");
    a_pin_polarity: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE1]
        io_out == (macro_reg ^ POLARITY))
        else $error("pin level does not follow polarity");
    a_preload_force: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE4]
        (take_edge && preload_req && !cfg_secure)
        |=> macro_reg == (($past(macro_reg) & ~$past(preload_mask)) | ($past(preload_value) & $past(preload_mask))))
        else $error("preload did not force the chosen levels");
    a_secure_block: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE6]
        (verify_req && cfg_secure) |=> (verify_valid && verify_denied && verify_data == pprsc_pkg::VERIFY_RST))
        else $error("secured readback not blocked");
    a_sig_read: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE5]
        sig_rd_req |=> (sig_valid && sig_data == $past(sig_store_reg)))
        else $error("signature read failed");
    a_sleep_freeze: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE9] [RULE15]
        asleep_now |=> ($stable(macro_reg) && $stable(io_out) && asleep))
        else $error("state moved while asleep");
    a_sleep_hiz: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE11]
        asleep_now |=> $stable(io_oe))
        else $error("output enable changed while asleep");
    a_sleep_inputs: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE10]
        asleep_now |=> ($stable(array_in[NI-1:0]) && $stable(io_level)))
        else $error("inputs passed while asleep");
    a_pin_term_use: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE12]
        !cfg_sleep_enable |=> array_in[NI] == $past(sleep_lvl))
        else $error("sleep pin not used as plain input");
    a_pin_term_off: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE13]
        cfg_sleep_enable |=> !array_in[NI])
        else $error("sleep pin term reached the array");
    a_image_size: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE14]
        cfg_sleep_enable |=> fuse_count == pprsc_pkg::FUSES_SLEEP)
        else $error("image size wrong with sleep fuse");
endmodule
`default_nettype wire

/* File: src/pprsc_pkg.sv */
// constants shared by the power, reset and security control block
`default_nettype none
package pprsc_pkg;
    // power-up clear interval, longest figure, and the clock period
    localparam int CLEAR_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 20;
    // longest time rounds down to whole cycles, never below one
    localparam int CLEAR_CYC_INT = (CLEAR_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : (CLEAR_TIME_NS / CLK_PERIOD_NS);
    localparam int CLR_CNT_W     = 7;
    localparam logic [CLR_CNT_W-1:0] CLEAR_CYC = CLR_CNT_W'(CLEAR_CYC_INT);
    localparam logic [CLR_CNT_W-1:0] CLR_CNT_RST = 7'h00;
    // user signature area size and reset content
    localparam int SIG_BITS = 64;
    localparam logic [SIG_BITS-1:0] SIG_RST = 64'h0000_0000_0000_0000;
    // configuration image sizes per mode
    localparam int FUSE_CNT_W = 13;
    localparam logic [FUSE_CNT_W-1:0] FUSES_BASIC = 13'h16c4;   // 5828 bits
    localparam logic [FUSE_CNT_W-1:0] FUSES_SIG   = 13'h1704;   // 5892 bits
    localparam logic [FUSE_CNT_W-1:0] FUSES_SLEEP = 13'h1705;   // 5893 bits
    // width of one configuration readback word
    localparam int VERIFY_W = 32;
    localparam logic [VERIFY_W-1:0] VERIFY_RST = 32'h0000_0000;
endpackage
`default_nettype wire

/* File: src/pprsc_pin_keep.sv */
// pin synchroniser with keeper: holds the last level of an undriven pin
`default_nettype none
module pprsc_pin_keep #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,    // system clock
    input  wire logic         reset_n,    // async reset, active low
    input  wire logic [W-1:0] pin_in,     // raw pin level
    input  wire logic [W-1:0] pin_driven, // an outside driver is active
    input  wire logic [W-1:0] own_oe,     // our own buffer drives the pin
    input  wire logic [W-1:0] own_out,    // our own driven value
    output logic      [W-1:0] level       // kept, synchronised level
);
    logic [W-1:0] pin_s1_reg;
    logic [W-1:0] pin_s2_reg;
    logic [W-1:0] drv_s1_reg;
    logic [W-1:0] drv_s2_reg;

    // two flops before anything looks at the pin
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            drv_s1_reg <= '0;
            drv_s2_reg <= '0;
        end else begin
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
            drv_s1_reg <= pin_driven;
            drv_s2_reg <= drv_s1_reg;
        end
    end

    // keeper: a floating pin keeps its last level, no pull current needed
    generate
        for (genvar i = 0; i < W; i++) begin : g_keep
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    level[i] <= 1'b0;
                end else if (drv_s2_reg[i]) begin
                    level[i] <= pin_s2_reg[i];     // [RULE8]
                end else if (own_oe[i]) begin
                    level[i] <= own_out[i];        // [RULE8]
                end
            end
        end
    endgenerate

    a_keep_hold: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE8]
        (drv_s2_reg == '0 && own_oe == '0) |=> $stable(level))
        else $error("keeper lost an undriven pin level");
endmodule
`default_nettype wire

/* File: tb/pprsc_board.sv */
// board-side model: drives the input and i/o pins and lets released lines float
`default_nettype none
module pprsc_board #(
    parameter int NI = 12, // dedicated input pins
    parameter int NM = 10  // i/o pins
) (
    input  wire logic          clk_sys,   // system clock
    input  wire logic [NI-1:0] in_en,     // board drives each input pin
    input  wire logic [NI-1:0] in_val,    // board input levels
    input  wire logic [NM-1:0] io_en,     // board drives each i/o pin
    input  wire logic [NM-1:0] io_val,    // board i/o levels
    input  wire logic [NM-1:0] dev_oe,    // device drives each i/o pin
    input  wire logic [NM-1:0] dev_out,   // device i/o levels
    output logic      [NI-1:0] in_pin,    // input pin levels
    output logic      [NI-1:0] in_driven, // input driver active
    output logic      [NM-1:0] io_in,     // i/o pin levels
    output logic      [NM-1:0] io_driven  // i/o driver active
);
    timeunit 1ns;
    timeprecision 1ps;
    // levels change just after the edge so setup holds at the next one
    // a line nobody drives flips every cycle, so only the keeper can hold it
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < NI; i++) begin
            in_pin[i] <= in_en[i] ? in_val[i] : ~in_pin[i];
        end
        for (int i = 0; i < NM; i++) begin
            io_in[i] <= io_en[i] ? io_val[i] : (dev_oe[i] ? dev_out[i] : ~io_in[i]);
        end
    end
    // driver flags follow the enables directly
    assign in_driven = in_en;
    assign io_driven = io_en;
endmodule
`default_nettype wire

/* File: tb/pprsc_ctrl_tb.sv */
// self-checking bench for the power, reset, security and sleep control block
`default_nettype none
module pprsc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NI = 12;
    localparam int NM = 10;
    localparam logic [NM-1:0] POL = 10'h2a5;
    logic clk_sys, reset_n, shared_input_sleep_pin, cfg_sleep_enable, cfg_sig_present, cfg_secure;
    logic preload_req, verify_req, sig_wr_req, sig_rd_req, ready, asleep, preload_denied;
    logic verify_valid, verify_denied, sig_valid;
    logic [NI-1:0] in_en, in_val, in_pin, in_driven;
    logic [NI:0]   array_in;
    logic [NM-1:0] io_en, io_val, io_in, io_driven, array_next, array_oe, preload_mask, preload_value;
    logic [NM-1:0] io_out, io_oe, feedback, io_level, ev, fz;
    logic [31:0]   cfg_word, verify_data;
    logic [63:0]   sig_wr_data, sig_data;
    logic [12:0]   fuse_count;
    int            miscompares, n_checks, cyc, n;

    pprsc_ctrl #(.NI(NI), .NM(NM), .POLARITY(POL)) dut (.clk_sys, .reset_n, .in_pin, .in_driven, .io_in,
        .io_driven, .shared_input_sleep_pin, .cfg_sleep_enable, .cfg_sig_present, .cfg_secure, .array_next,
        .array_oe, .preload_req, .preload_mask, .preload_value, .verify_req, .cfg_word, .sig_wr_req,
        .sig_wr_data, .sig_rd_req, .io_out, .io_oe, .feedback, .array_in, .io_level, .ready, .asleep,
        .preload_denied, .verify_valid, .verify_data, .verify_denied, .sig_valid, .sig_data, .fuse_count);
    pprsc_board #(.NI(NI), .NM(NM)) board (.clk_sys, .in_en, .in_val, .io_en, .io_val, .dev_oe(io_oe),
        .dev_out(io_out), .in_pin, .in_driven, .io_in, .io_driven);

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic print_verdict();
        $display("checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // clear must hold registers low, show the polarity, and last exactly the clear count
    task automatic t_reset();
        tick(1);
        #1 chk(feedback, 0);
        chk(io_out, POL);
        @(posedge clk_sys) reset_n <= 1'b1;
        n = 0;
        while (ready !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1 n++;
            if (n == 40) chk(feedback, 0);
        end
        chk(n, 50);
        $display("test reset done");
    endtask

    // array results land one edge later, one new vector every second edge, through the polarity
    task automatic t_macro();
        logic [NM-1:0] v [4] = '{10'h155, 10'h2aa, 10'h001, 10'h3ff};
        foreach (v[i]) begin
            @(posedge clk_sys);
            array_next <= v[i];
            array_oe <= ~v[i];
            ev = ~v[i];
            @(posedge clk_sys);
            #1 chk(feedback, v[i]);
            chk(io_out, v[i] ^ POL);
            chk(io_oe, ev);
        end
        $display("test macrocell done");
    endtask

    // two preloads in a row force ones and zeros bit by bit, then the array takes over
    task automatic t_preload();
        @(posedge clk_sys) array_next <= 10'h0f0;
        @(posedge clk_sys);
        preload_req <= 1'b1;
        preload_mask <= 10'h00f;
        preload_value <= 10'h3f5;
        @(posedge clk_sys);
        preload_mask <= 10'h3c0;
        preload_value <= 10'h155;
        #1 chk(feedback, 10'h0f5);
        @(posedge clk_sys) preload_req <= 1'b0;
        #1 chk(feedback, 10'h175);
        chk(preload_denied, 0);
        tick(1);
        #1 chk(feedback, 10'h0f0);
        $display("test preload done");
    endtask

    // readback and signature open, then the security fuse goes in as the last step
    task automatic t_secure();
        @(posedge clk_sys);
        verify_req <= 1'b1;
        cfg_word <= 32'h1234_abcd;
        sig_wr_req <= 1'b1;
        sig_wr_data <= 64'h0123_4567_89ab_cdef;
        @(posedge clk_sys);
        verify_req <= 1'b0;
        sig_wr_req <= 1'b0;
        sig_rd_req <= 1'b1;
        #1 chk({verify_valid, verify_denied, verify_data}, {2'b10, 32'h1234_abcd});
        @(posedge clk_sys) sig_rd_req <= 1'b0;
        #1 chk(sig_valid, 1);
        chk(sig_data, 64'h0123_4567_89ab_cdef);
        chk(verify_valid, 0);
        @(posedge clk_sys);
        cfg_secure <= 1'b1;
        verify_req <= 1'b1;
        @(posedge clk_sys);
        verify_req <= 1'b0;
        preload_req <= 1'b1;
        preload_mask <= 10'h3ff;
        preload_value <= 10'h000;
        array_next <= 10'h2c3;
        sig_rd_req <= 1'b1;
        #1 chk({verify_valid, verify_denied, verify_data}, {2'b11, 32'h0});
        @(posedge clk_sys);
        preload_req <= 1'b0;
        sig_rd_req <= 1'b0;
        #1 chk(preload_denied, 1);
        chk(feedback, 10'h2c3);
        chk({sig_valid, sig_data}, {1'b1, 64'h0123_4567_89ab_cdef});
        $display("test security done");
    endtask

    // released pins keep their last driven level; sleep pin is a plain input when not enabled
    task automatic t_keep();
        @(posedge clk_sys);
        in_val <= 12'ha5c;
        io_en <= '1;
        io_val <= 10'h155;
        array_oe <= '0;
        shared_input_sleep_pin <= 1'b1;
        tick(6);
        in_en <= '0;
        io_en <= '0;
        tick(8);
        #1 chk(array_in, {1'b1, 12'ha5c});
        chk(io_level, 10'h155);
        $display("test keeper done");
    endtask

    // image size per mode, then freeze while asleep and resume on wake
    task automatic t_sleep();
        logic [1:0]  m [3] = '{2'b10, 2'b00, 2'b11};
        logic [12:0] f [3] = '{13'h1704, 13'h16c4, 13'h1705};
        @(posedge clk_sys) shared_input_sleep_pin <= 1'b0;
        foreach (m[i]) begin
            @(posedge clk_sys) {cfg_sig_present, cfg_sleep_enable} <= m[i];
            tick(4);
            #1 chk(fuse_count, f[i]);
        end
        @(posedge clk_sys);
        array_next <= 10'h0a5;
        array_oe <= 10'h30f;
        tick(2);
        shared_input_sleep_pin <= 1'b1;
        tick(6);
        #1 chk(asleep, 1);
        chk(feedback, 10'h0a5);
        fz = io_out;
        @(posedge clk_sys);
        array_next <= 10'h35a;
        array_oe <= '0;
        cfg_secure <= 1'b0; // fuse off, so a preload leaking through sleep would clear the flag
        in_en <= '1;
        in_val <= 12'h0ff;
        preload_req <= 1'b1;
        @(posedge clk_sys) preload_req <= 1'b0;
        tick(5);
        #1 chk(feedback, 10'h0a5);
        chk(io_out, fz);
        chk(io_oe, 10'h30f);
        chk(array_in, {1'b0, 12'ha5c});
        chk(preload_denied, 1);
        @(posedge clk_sys) shared_input_sleep_pin <= 1'b0;
        tick(6);
        #1 chk(asleep, 0);
        chk({feedback, io_oe}, {10'h35a, 10'h000});
        chk(array_in, {1'b0, 12'h0ff});
        $display("test sleep done");
    endtask

    // a second clear in mid-run must drop the registers at once, not at the next edge
    task automatic t_reclear();
        @(posedge clk_sys) reset_n <= 1'b0;
        #1 chk(feedback, 0);
        chk(io_out, POL);
        chk(ready, 0);
        @(posedge clk_sys) reset_n <= 1'b1;
        tick(49);
        #1 chk(ready, 0);
        tick(1);
        #1 chk(ready, 1);
        $display("test reclear done");
    endtask

    // free-running clock; no stimulus moves until the clear interval is over
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // hang guard: far beyond the fewer than two hundred cycles the tests need
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            $display("ERROR at %0t: timeout", $time);
            print_verdict();
        end
    end

    // main sequence
    initial begin
        {miscompares, n_checks, cyc} = '0;
        {reset_n, shared_input_sleep_pin, cfg_sleep_enable, cfg_sig_present, cfg_secure} = '0;
        {preload_req, verify_req, sig_wr_req, sig_rd_req} = '0;
        {io_en, io_val, preload_mask, preload_value, array_oe} = '0;
        in_en = '1;
        in_val = '0;
        array_next = 10'h3ff;
        cfg_word = '0;
        sig_wr_data = '0;
        t_reset();
        t_macro();
        t_preload();
        t_keep();
        t_secure();
        t_sleep();
        t_reclear();
        print_verdict();
    end
endmodule
`default_nettype wire
